/* hw/bldc_pkg.sv */
`default_nettype none
package bldc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_HZ = 96_000;
  // Rounded down to whole cycles; nominal rate is approximate anyway
  localparam int PWM_CYCLES = CLK_HZ / PWM_HZ;
  localparam int POLE_PAIRS = 2;
  localparam int HALL_EDGES_REV = 6 * POLE_PAIRS;
  localparam longint RPM_NUM_L = 64'(60) * CLK_HZ / HALL_EDGES_REV;
  localparam int RPM_NUM = int'(RPM_NUM_L);
  localparam int MIN_RPM = 400;
  // Below half the least regulated speed the rotor counts as stopped
  localparam int STALL_CYCLES = RPM_NUM / MIN_RPM * 2;
  localparam int NUM_W = 29;
  localparam int IV_W = 22;
  localparam int SPD_W = 16;
  localparam int SETP_W = 12;
  localparam int DUTY_W = 11;
  localparam int GAIN_SHIFT = 8;
  localparam int PULSE_DIV_SIX = 1;
  localparam int PULSE_DIV_TWO = 3;
  localparam logic [15:0] MAX_RPM = 16'hEA60;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MAXSPD = 4'h1;
  localparam logic [3:0] ADDR_ERRDLY = 4'h2;
  localparam logic [3:0] ADDR_KP = 4'h3;
  localparam logic [3:0] ADDR_KI = 4'h4;
  localparam logic [3:0] ADDR_SPEED = 4'h5;
  localparam logic [3:0] ADDR_TARGET = 4'h6;
  localparam logic [3:0] ADDR_STAT = 4'h7;
  localparam logic [3:0] ADDR_INTCLR = 4'h8;
  localparam logic [3:0] ADDR_INTEN = 4'h9;
  localparam logic [3:0] ADDR_LIMLVL = 4'hA;
  localparam logic [3:0] ADDR_LIMDUR = 4'hB;

  localparam int CTRL_ERRMODE = 0;
  localparam int CTRL_TWOPULSE = 1;
  localparam int CTRL_NOBRAKE = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] MAXSPD_RST = 16'hEA60;
  localparam logic [15:0] ERRDLY_RST = 16'h03E8;
  localparam logic [7:0] KP_RST = 8'h10;
  localparam logic [7:0] KI_RST = 8'h02;
  localparam logic [15:0] LIMLVL_RST = 16'h03E8;
  localparam logic [15:0] LIMDUR_RST = 16'h0064;

  localparam int INT_W = 3;
  localparam int INT_LIMIT = 0;
  localparam int INT_STALL = 1;
  localparam int INT_HALLBAD = 2;

  typedef enum logic [2:0] {
    DRV_OFF = 3'b001,
    DRV_MOTOR = 3'b010,
    DRV_BRAKE = 3'b100
  } drive_t;
endpackage
`default_nettype wire

/* hw/speed_divider.sv */
`default_nettype none
// Restoring divider, one quotient bit per clock
module speed_divider #(
  parameter int NW = 29,
  parameter int DW = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Operands
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  // Result
  output logic done,
  output logic [NW-1:0] quo
);
  initial begin
    if (DW > NW || DW < 2) $error("speed_divider: bad widths");
  end

  logic [NW:0] rem;
  logic [NW-1:0] numSh;
  logic [$clog2(NW+1)-1:0] cnt;
  logic busy;
  logic [NW:0] trial;
  logic fits;

  assign trial = {rem[NW-1:0], numSh[NW-1]};
  assign fits = trial >= {{(NW+1-DW){1'b0}}, den};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem <= '0;
      numSh <= '0;
      quo <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= busy && cnt == 1;
      if (start) begin
        rem <= '0;
        numSh <= num;
        cnt <= ($clog2(NW+1))'(NW);
        busy <= 1'b1;
      end else if (busy) begin
        rem <= fits ? trial - {{(NW+1-DW){1'b0}}, den} : trial;
        quo <= {quo[NW-2:0], fits};
        numSh <= {numSh[NW-2:0], 1'b0};
        cnt <= cnt - 1'b1;
        busy <= cnt != 1;
      end
    end
  end
endmodule // speed_divider
`default_nettype wire

/* hw/bldc_speed_controller.sv */
`default_nettype none
// Behaviour
// - Target speed scales from setpoint input
// - Drive saturates at full duty when short
// - Regulated speed never above configured maximum
// - Direction low anticlockwise, high clockwise
// - Status output: error or speed pulses
// - Error mode: high after configurable limiter delay
// - Error mode: low once limiting ends
// - Six status pulses per revolution by default
// - Closed-loop PI speed control via PWM
// - Commutation from digital Hall states
// - Speed from interval between Hall edges
// - PWM period about 96 kHz
// - Regulation valid from about 400 rpm
// - Short windings when decelerating
// - Limit and gains adjustable by software
// - Pulse count selectable six or two
// - Maximum speed setting up to 60000
// - Braking can be disabled
// - Twelve Hall edges per revolution
module bldc_speed_controller
  import bldc_pkg::*;
#(
  parameter int STALL = STALL_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Setpoint from converter, same clock
  input wire logic [SETP_W-1:0] setpointCode,
  // Pins
  input wire logic dirPin,
  input wire logic [2:0] hallPin,
  input wire logic limitPin,
  // Power stage
  output logic [2:0] highGate,
  output logic [2:0] lowGate,
  // Status and limiter settings
  output logic statusPulseOut,
  output logic [15:0] limitLevel,
  output logic [15:0] limitTime,
  output logic irq
);
  initial begin
    if (STALL < 2 || STALL >= 2**IV_W) $error("STALL out of range");
  end

  // Synchronisers
  logic [2:0] hallS1, hallS2, hallQ;
  logic dirS1, dirS2, limS1, limS2, limQ;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hallS1 <= '0;
      hallS2 <= '0;
      hallQ <= '0;
      dirS1 <= 1'b0;
      dirS2 <= 1'b0;
      limS1 <= 1'b0;
      limS2 <= 1'b0;
      limQ <= 1'b0;
    end else begin
      hallS1 <= hallPin;
      hallS2 <= hallS1;
      hallQ <= hallS2;
      dirS1 <= dirPin;
      dirS2 <= dirS1;
      limS1 <= limitPin;
      limS2 <= limS1;
      limQ <= limS2;
    end
  end

  // Registers
  logic [2:0] ctrl;
  logic [15:0] maxSpd, errDelay, speed, target;
  logic [7:0] kp, ki;
  logic [INT_W-1:0] intStat, intEn;
  logic errMode, twoPulse, noBrake;
  assign errMode = ctrl[CTRL_ERRMODE];
  assign twoPulse = ctrl[CTRL_TWOPULSE];
  assign noBrake = ctrl[CTRL_NOBRAKE];

  logic wrCtrl, wrMax, wrDly, wrKp, wrKi, wrClr, wrEn, wrLvl, wrDur;
  assign wrCtrl = regWr && regAddr == ADDR_CTRL;
  assign wrMax = regWr && regAddr == ADDR_MAXSPD;
  assign wrDly = regWr && regAddr == ADDR_ERRDLY;
  assign wrKp = regWr && regAddr == ADDR_KP;
  assign wrKi = regWr && regAddr == ADDR_KI;
  assign wrClr = regWr && regAddr == ADDR_INTCLR;
  assign wrEn = regWr && regAddr == ADDR_INTEN;
  assign wrLvl = regWr && regAddr == ADDR_LIMLVL;
  assign wrDur = regWr && regAddr == ADDR_LIMDUR;

  // Writes above the top speed are clipped, not refused
  logic [15:0] maxWr;
  assign maxWr = regWdata > MAX_RPM ? MAX_RPM : regWdata;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      maxSpd <= MAXSPD_RST;
      errDelay <= ERRDLY_RST;
      kp <= KP_RST;
      ki <= KI_RST;
      intEn <= '0;
      limitLevel <= LIMLVL_RST;
      limitTime <= LIMDUR_RST;
    end else begin
      if (wrCtrl) ctrl <= regWdata[2:0];
      if (wrMax) maxSpd <= maxWr;
      if (wrDly) errDelay <= regWdata;
      if (wrKp) kp <= regWdata[7:0];
      if (wrKi) ki <= regWdata[7:0];
      if (wrEn) intEn <= regWdata[INT_W-1:0];
      if (wrLvl) limitLevel <= regWdata;
      if (wrDur) limitTime <= regWdata;
    end
  end

  logic [15:0] rdMux;
  assign rdMux =
    regAddr == ADDR_CTRL ? {13'h0, ctrl} :
    regAddr == ADDR_MAXSPD ? maxSpd :
    regAddr == ADDR_ERRDLY ? errDelay :
    regAddr == ADDR_KP ? {8'h0, kp} :
    regAddr == ADDR_KI ? {8'h0, ki} :
    regAddr == ADDR_SPEED ? speed :
    regAddr == ADDR_TARGET ? target :
    regAddr == ADDR_STAT ? {13'h0, intStat} :
    regAddr == ADDR_INTEN ? {13'h0, intEn} :
    regAddr == ADDR_LIMLVL ? limitLevel :
    regAddr == ADDR_LIMDUR ? limitTime : 16'h0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) regRdata <= '0;
    else regRdata <= regRd ? rdMux : 16'h0000;
  end

  // Hall decoding
  logic hallEdge, hallBad;
  assign hallEdge = hallS2 != hallQ;
  assign hallBad = hallS2 == 3'b000 || hallS2 == 3'b111;

  // Interval timing
  logic [IV_W-1:0] ivCnt;
  logic stalled, divStart, divDone, stallHit;
  logic [NUM_W-1:0] quo;
  logic [IV_W-1:0] ivLatch;
  assign stallHit = ivCnt == IV_W'(STALL - 1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ivCnt <= '0;
      ivLatch <= '0;
      stalled <= 1'b1;
      divStart <= 1'b0;
    end else begin
      divStart <= hallEdge && !stalled;
      if (hallEdge) begin
        ivLatch <= ivCnt + 1'b1;
        ivCnt <= '0;
        stalled <= 1'b0;
      end else if (stallHit) begin
        stalled <= 1'b1;
      end else if (!stalled) begin
        ivCnt <= ivCnt + 1'b1;
      end
    end
  end

  // numerator assumes twelve edges per turn
  speed_divider #(
    .NW(NUM_W),
    .DW(IV_W)
  ) u_div (
    .clk(mclk),
    .rst(rst),
    .start(divStart),
    .num(NUM_W'(RPM_NUM)),
    .den(ivLatch),
    .done(divDone),
    .quo(quo)
  );

  // Speed saturates at the register width
  logic [15:0] quoSat;
  assign quoSat = |quo[NUM_W-1:SPD_W] ? 16'hFFFF : quo[SPD_W-1:0];

  // slower than the stall limit reads as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) speed <= '0;
    else if (stalled) speed <= '0;
    else if (divDone) speed <= quoSat;
  end

  logic [SETP_W+15:0] prod;
  assign prod = setpointCode * maxSpd;
  // scaling cannot pass the configured maximum
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) target <= '0;
    else target <= prod[SETP_W+15:SETP_W];
  end

  // PWM carrier
  logic [DUTY_W-1:0] pwmCnt, duty, next_duty;
  logic pwmWrap, pwmOn;
  assign pwmWrap = pwmCnt == DUTY_W'(PWM_CYCLES - 1);
  // duty of a full period keeps the stage on
  assign pwmOn = pwmCnt < duty;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) pwmCnt <= '0;
    else pwmCnt <= pwmWrap ? '0 : pwmCnt + 1'b1;
  end

  // PI loop, evaluated once per carrier period
  localparam logic signed [28:0] INT_MAX = 29'(PWM_CYCLES * 256);
  localparam logic signed [28:0] DUTY_MAX = 29'(PWM_CYCLES);
  logic signed [17:0] err;
  logic signed [27:0] pTerm, iTerm, integ, next_integ;
  logic signed [28:0] sumI, sumD, dutyS;
  assign err = $signed({2'b00, target}) - $signed({2'b00, speed});
  // Widen before multiplying so large errors cannot wrap
  assign pTerm = 28'(err) * 28'($signed({1'b0, kp}));
  assign iTerm = 28'(err) * 28'($signed({1'b0, ki}));
  assign sumI = integ + iTerm;
  // Anti-windup: integrator held within the duty range
  assign next_integ = sumI < 0 ? '0 :
    sumI > INT_MAX ? 28'(INT_MAX) : sumI[27:0];
  assign sumD = integ + pTerm;
  assign dutyS = sumD >>> GAIN_SHIFT;
  // clamp controller output to the carrier
  assign next_duty = dutyS < 0 ? '0 :
    dutyS > DUTY_MAX ? DUTY_W'(PWM_CYCLES) : dutyS[DUTY_W-1:0];

  // Drive state
  drive_t drv, next_drv;
  logic wantBrake;
  // brake while too fast with no drive
  assign wantBrake = !noBrake && speed > target && next_duty == '0;
  always_comb begin
    next_drv = drv;
    case (drv)
      DRV_OFF: if (target != '0) next_drv = DRV_MOTOR;
      DRV_MOTOR: begin
        if (target == '0 && stalled) next_drv = DRV_OFF;
        else if (wantBrake) next_drv = DRV_BRAKE;
      end
      DRV_BRAKE: begin
        if (target == '0 && stalled) next_drv = DRV_OFF;
        else if (!wantBrake) next_drv = DRV_MOTOR;
      end
      default: next_drv = DRV_OFF;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drv <= DRV_OFF;
      integ <= '0;
      duty <= '0;
    end else if (pwmWrap) begin
      drv <= next_drv;
      integ <= next_drv == DRV_OFF ? '0 : next_integ;
      duty <= next_drv == DRV_MOTOR ? next_duty : '0;
    end
  end

  // Six-step table, phase one-hot {C,B,A}
  logic [2:0] hiPh, loPh, cmdHi, cmdLo;
  always_comb begin
    case (hallS2)
      3'b101: begin hiPh = 3'b001; loPh = 3'b010; end
      3'b100: begin hiPh = 3'b001; loPh = 3'b100; end
      3'b110: begin hiPh = 3'b010; loPh = 3'b100; end
      3'b010: begin hiPh = 3'b010; loPh = 3'b001; end
      3'b011: begin hiPh = 3'b100; loPh = 3'b001; end
      3'b001: begin hiPh = 3'b100; loPh = 3'b010; end
      default: begin hiPh = 3'b000; loPh = 3'b000; end
    endcase
  end
  assign cmdHi = dirS2 ? hiPh : loPh;
  assign cmdLo = dirS2 ? loPh : hiPh;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      highGate <= '0;
      lowGate <= '0;
    end else begin
      highGate <= drv == DRV_MOTOR && pwmOn ? cmdHi : 3'b000;
      lowGate <= drv == DRV_BRAKE ? 3'b111 :
        drv == DRV_MOTOR ? cmdLo : 3'b000;
    end
  end

  // Status output
  logic [1:0] edgeDiv;
  logic [15:0] errCnt;
  logic pulseLvl, divEnd, errReached;
  // divide edges by one or three
  assign divEnd = edgeDiv == 2'(twoPulse ? PULSE_DIV_TWO : PULSE_DIV_SIX);
  assign errReached = errCnt >= errDelay;

  // one toggle per edge gives six pulses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      edgeDiv <= 2'h0;
      pulseLvl <= 1'b0;
    end else if (hallEdge) begin
      edgeDiv <= divEnd ? 2'h1 : edgeDiv + 1'b1;
      if (divEnd) pulseLvl <= !pulseLvl;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) errCnt <= '0;
    else if (!limS2) errCnt <= '0;
    else if (!errReached) errCnt <= errCnt + 1'b1;
  end

  // rise only after the programmed delay
  // fall as soon as limiting ends
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) statusPulseOut <= 1'b0;
    else if (errMode) statusPulseOut <= limS2 && errReached;
    else statusPulseOut <= pulseLvl;
  end

  // Interrupts: a new event wins over a clear in the same cycle
  logic [INT_W-1:0] intSet, intClr;
  assign intSet[INT_LIMIT] = limS2 && !limQ;
  assign intSet[INT_STALL] = stallHit && !stalled && !hallEdge;
  assign intSet[INT_HALLBAD] = hallEdge && hallBad;
  assign intClr = wrClr ? regWdata[INT_W-1:0] : '0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intStat <= '0;
      irq <= 1'b0;
    end else begin
      intStat <= (intStat & ~intClr) | intSet;
      irq <= |(((intStat & ~intClr) | intSet) & intEn);
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_measEdge;
    hallEdge && !stalled;
  endsequence
  sequence s_limitHeld;
    errMode && limS2 && errReached;
  endsequence

  property p_measure;
    s_measEdge |-> ##[30:33] divDone;
  endproperty
  a_measure: assert property (p_measure)
    else $error("speed result late");

  property p_errDelay;
    errMode && $rose(statusPulseOut) |-> $past(limS2) && $past(errReached);
  endproperty
  a_errDelay: assert property (p_errDelay)
    else $error("error output rose early");

  property p_errHigh;
    s_limitHeld ##1 (errMode && limS2) |-> statusPulseOut;
  endproperty
  a_errHigh: assert property (p_errHigh)
    else $error("error output missing");

  property p_errLow;
    errMode && !limS2 |=> !statusPulseOut;
  endproperty
  a_errLow: assert property (p_errLow)
    else $error("error output stuck high");

  property p_brake;
    drv == DRV_BRAKE |=> lowGate == 3'b111 && highGate == 3'b000;
  endproperty
  a_brake: assert property (p_brake)
    else $error("braking not shorting windings");

  property p_noBrake;
    noBrake && pwmWrap |=> drv != DRV_BRAKE;
  endproperty
  a_noBrake: assert property (p_noBrake)
    else $error("braked while disabled");

  property p_period;
    pwmWrap |=> !pwmWrap [*8];
  endproperty
  a_period: assert property (p_period)
    else $error("carrier period too short");

  property p_target;
    target <= maxSpd || $past(wrMax);
  endproperty
  a_target: assert property (p_target)
    else $error("target above maximum");

  property p_shoot;
    (highGate & lowGate) == 3'b000;
  endproperty
  a_shoot: assert property (p_shoot)
    else $error("same phase driven high and low");

  property p_fullDuty;
    duty == DUTY_W'(PWM_CYCLES) && drv == DRV_MOTOR && cmdHi != 3'b000
      |=> highGate != 3'b000;
  endproperty
  a_fullDuty: assert property (p_fullDuty)
    else $error("full duty not continuous");
endmodule // bldc_speed_controller
`default_nettype wire

/* sim/bldc_hall_model.sv */
`default_nettype none
// Rotor with digital Hall sensors, stepped by the bench
module bldc_hall_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bench control
  input wire logic run,
  input wire logic [15:0] period,
  // Sensor side
  output logic [2:0] hall,
  output logic step
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  logic [2:0] idx;
  logic [2:0] seq [6];
  // Sensors sit a third of a period apart
  assign seq = '{3'b101, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001};
  assign hall = seq[idx];
  // Stopped rotor keeps its last sensor state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      idx <= '0;
      step <= 1'b0;
    end else begin
      step <= 1'b0;
      if (run) begin
        cnt <= cnt + 16'h1;
        // Greater-or-equal survives a shortened period
        if (cnt >= period - 16'h1) begin
          cnt <= '0;
          idx <= (idx == 3'h5) ? 3'h0 : idx + 3'h1;
          step <= 1'b1;
        end
      end
    end
  end
endmodule // bldc_hall_model
`default_nettype wire

/* sim/bldc_speed_controller_tb.sv */
`default_nettype none
module bldc_speed_controller_tb;
  import bldc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STALL_SIM = 10000;
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [15:0] d;
    logic [11:0] sp;
    logic [15:0] e;
  } row_t;
  logic mclk, rst, regWr, regRd, dirPin, limitPin, run, step, irq;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, limitLevel, limitTime, period, v;
  logic [11:0] setpointCode;
  logic [2:0] hallPin, highGate, lowGate, hi, lo;
  logic statusPulseOut;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  row_t rows [18] = '{
    '{1'b0, ADDR_CTRL, 16'h0, 12'h0, 16'h0000},
    '{1'b0, ADDR_MAXSPD, 16'h0, 12'h0, 16'hEA60},
    '{1'b0, ADDR_ERRDLY, 16'h0, 12'h0, 16'h03E8},
    '{1'b0, ADDR_KP, 16'h0, 12'h0, 16'h0010},
    '{1'b0, ADDR_KI, 16'h0, 12'h0, 16'h0002},
    '{1'b0, ADDR_INTEN, 16'h0, 12'h0, 16'h0000},
    '{1'b0, 4'hC, 16'h0, 12'h0, 16'h0000},
    '{1'b1, ADDR_MAXSPD, 16'hFFFF, 12'h0, 16'h0},
    '{1'b0, ADDR_MAXSPD, 16'h0, 12'h0, 16'hEA60},
    '{1'b1, 4'hC, 16'h1234, 12'h0, 16'h0},
    '{1'b0, 4'hC, 16'h0, 12'h0, 16'h0000},
    '{1'b1, ADDR_MAXSPD, 16'h03E8, 12'h800, 16'h0},
    '{1'b0, ADDR_TARGET, 16'h0, 12'h800, 16'h01F4},
    '{1'b0, ADDR_TARGET, 16'h0, 12'hFFF, 16'h03E7},
    '{1'b1, ADDR_KP, 16'h0020, 12'hFFF, 16'h0},
    '{1'b0, ADDR_KP, 16'h0, 12'hFFF, 16'h0020},
    '{1'b1, ADDR_INTCLR, 16'h0007, 12'hFFF, 16'h0},
    '{1'b0, ADDR_INTCLR, 16'h0, 12'hFFF, 16'h0000}
  };

  bldc_speed_controller #(.STALL(STALL_SIM)) DUT (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .setpointCode(setpointCode), .dirPin(dirPin), .hallPin(hallPin),
    .limitPin(limitPin), .highGate(highGate), .lowGate(lowGate),
    .statusPulseOut(statusPulseOut), .limitLevel(limitLevel),
    .limitTime(limitTime), .irq(irq));
  bldc_hall_model motor (.mclk(mclk), .rst(rst), .run(run),
    .period(period), .hall(hallPin), .step(step));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // Lets one PWM wrap pass, then collects every gate seen on
  task automatic scan(output logic [2:0] h, output logic [2:0] l);
    h = '0;
    l = '0;
    repeat (1200) @(negedge mclk);
    repeat (1100) @(negedge mclk) begin
      h |= highGate;
      l |= lowGate;
    end
  endtask

  // Window covers exactly six sensor edges
  task automatic pulses(output int c);
    logic prev;
    @(posedge step);
    repeat (10) @(negedge mclk);
    c = 0;
    prev = statusPulseOut;
    repeat (6 * 2000) @(negedge mclk) begin
      if (statusPulseOut && !prev) c++;
      prev = statusPulseOut;
    end
  endtask

  task automatic test_done;
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    test_done;
  end

  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    setpointCode = '0;
    dirPin = 1'b1;
    limitPin = 1'b0;
    run = 1'b0;
    period = 16'd8000;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk(limitLevel, 16'h03E8);
    chk(limitTime, 16'h0064);
    chk({15'h0, irq}, 16'h0);
    foreach (rows[i]) begin
      setpointCode <= rows[i].sp;
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, v);
        chk(v, rows[i].e);
      end
    end
    // Stalled rotor, target set: commutation from sensor state
    scan(hi, lo);
    chk({10'h0, hi, lo}, {10'h0, 3'b001, 3'b010});
    dirPin <= 1'b0;
    scan(hi, lo);
    chk({10'h0, hi, lo}, {10'h0, 3'b010, 3'b001});
    dirPin <= 1'b1;
    run <= 1'b1;
    repeat (3 * 8000 + 200) @(posedge mclk);
    rd(ADDR_SPEED, v);
    chk(v, 16'(RPM_NUM / 8000));
    // Rotor far above target: windings shorted
    scan(hi, lo);
    chk({10'h0, hi, lo}, {10'h0, 3'b000, 3'b111});
    wr(ADDR_CTRL, 16'h0004);
    scan(hi, lo);
    chk({12'h0, hi, lo == 3'b111}, 16'h0);
    wr(ADDR_CTRL, 16'h0000);
    period <= 16'd2000;
    pulses(n);
    chk(16'(n), 16'h3);
    rd(ADDR_SPEED, v);
    chk(v, 16'hFFFF);
    wr(ADDR_CTRL, 16'h0002);
    pulses(n);
    chk(16'(n), 16'h1);
    run <= 1'b0;
    repeat (STALL_SIM + 200) @(posedge mclk);
    rd(ADDR_SPEED, v);
    chk(v, 16'h0000);
    rd(ADDR_STAT, v);
    chk(v & 16'h0002, 16'h0002);
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_ERRDLY, 16'h0014);
    wr(ADDR_LIMLVL, 16'h0123);
    wr(ADDR_INTCLR, 16'h0007);
    wr(ADDR_INTEN, 16'h0001);
    @(negedge mclk);
    chk(limitLevel, 16'h0123);
    @(posedge mclk);
    limitPin <= 1'b1;
    repeat (15) @(negedge mclk);
    chk({15'h0, statusPulseOut}, 16'h0);
    repeat (12) @(negedge mclk);
    chk({15'h0, statusPulseOut}, 16'h1);
    chk({15'h0, irq}, 16'h1);
    @(posedge mclk);
    limitPin <= 1'b0;
    repeat (5) @(negedge mclk);
    chk({15'h0, statusPulseOut}, 16'h0);
    wr(ADDR_INTCLR, 16'h0001);
    repeat (2) @(negedge mclk);
    chk({15'h0, irq}, 16'h0);
    // Masked event must still latch in status
    wr(ADDR_INTEN, 16'h0000);
    limitPin <= 1'b1;
    repeat (30) @(negedge mclk);
    chk({15'h0, irq}, 16'h0);
    rd(ADDR_STAT, v);
    chk(v & 16'h0001, 16'h0001);
    limitPin <= 1'b0;
    test_done;
  end
endmodule // bldc_speed_controller_tb
`default_nettype wire
